/* brownout_defs.svh */
`ifndef BROWNOUT_DEFS_SVH
`define BROWNOUT_DEFS_SVH

// register bus geometry
`define ADDR_W            16
`define DATA_W            8

// register offsets
`define REG_HOLD_RELEASE  16'h2107
`define REG_SOURCE_SELECT 16'h2108
`define REG_LOWEST_LEVEL  16'h2109
`define REG_LOWEST_GAIN   16'h210a
`define REG_LOWEST_LIMIT  16'h210b
`define REG_ENGINE_ENABLE 16'h210d
`define REG_AUTO_RESTART  16'h210e

// field positions
`define BIT_HOLD_RELEASE  0
`define BIT_INPUT_SELECT  0
`define BIT_ENGINE_EN     0
`define BIT_LIMITER_EN    1
`define BIT_SPK_RECOVER   0
`define BIT_BAT_RECOVER   1
`define BIT_THERM_RECOVER 2
`define BIT_OVC_RECOVER   3

// reset values and fillers
`define RESET_BIT         1'b0
`define RESET_BYTE        8'h00
`define ZERO_BYTE         8'h00

// deepest-level codes, larger code is deeper
`define LEVEL_W           3
`define LEVEL_INACTIVE    3'h0
`define LEVEL_3           3'h1
`define LEVEL_2           3'h2
`define LEVEL_1           3'h3
`define LEVEL_0           3'h4

// fixed-point layouts
`define GAIN_INT_W        5
`define GAIN_FRAC_W       3
`define LIMIT_INT_W       4
`define LIMIT_FRAC_W      4

// capture slots
`define TRACK_COUNT       3
`define TRACK_LEVEL       0
`define TRACK_GAIN        1
`define TRACK_LIMIT       2

`endif

/* brownout_engine_status_ctrl.sv */
// Notes on behaviour
// RQ1 - writing one to the hold-release bit frees the engine; zero does nothing
// RQ2 - source select zero picks speaker-supply channel, one picks battery rail
// RQ3 - three-bit deepest level: 0 inactive, 1..4 levels 3..0, rest reserved
// RQ4 - each read of the deepest level reloads it with the current level
// RQ5 - deepest gain holds largest attenuation since last read, 5.3 format
// RQ6 - deepest limiter holds lowest limiter setting since last read, 4.4 format; the capture keeps the highest value instead
// RQ7 - enable bit 1 turns the limiter on, resets to zero
// RQ8 - enable bit 0 turns the whole engine on, resets to zero
// RQ9 - restart bit 3 set makes overcurrent recovery automatic
// RQ10 - restart bit 2 set makes thermal shutdown recovery automatic
// RQ11 - restart bit 1 set makes battery-rail lockout recovery automatic
// RQ12 - restart bit 0 set makes speaker-rail lockout recovery automatic
// RQ13 - hold-release register reads zero and acts as a one-cycle pulse
`timescale 1ns/1ps
`include "brownout_defs.svh"

module brownout_engine_status_ctrl
	import brownout_pkg::*;
(
	input  wire logic                      clk,
	input  wire logic                      rst,
	input  wire brownout_pkg::reg_addr_type reg_addr,
	input  wire brownout_pkg::reg_data_type reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output      brownout_pkg::reg_data_type reg_rdata_q,
	input  wire brownout_pkg::level_type    level_now,
	input  wire brownout_pkg::gain_type     gain_now,
	input  wire brownout_pkg::limiter_type  limiter_now,
	output      logic                      hold_release_q,
	output      logic                      engine_input_select_q,
	output      logic                      engine_enable_q,
	output      logic                      limiter_enable_q,
	output      logic                      overcurrent_auto_recover_q,
	output      logic                      thermal_auto_recover_q,
	output      logic                      battery_rail_auto_recover_q,
	output      logic                      speaker_rail_auto_recover_q
);
	import brownout_pkg::*;

	function automatic logic hit(input reg_addr_type a,
	                             input reg_addr_type off);
		hit = (a == off);
	endfunction

	function automatic reg_addr_type track_addr(input int slot);
		case (slot)
			`TRACK_LEVEL: track_addr = `REG_LOWEST_LEVEL;
			`TRACK_GAIN:  track_addr = `REG_LOWEST_GAIN;
			default:      track_addr = `REG_LOWEST_LIMIT;
		endcase
	endfunction

	logic         wr_hold;
	logic         wr_source;
	logic         wr_enable;
	logic         wr_restart;
	reg_data_type now_vec  [`TRACK_COUNT];
	reg_data_type held_vec [`TRACK_COUNT];

	assign wr_hold    = reg_wr && hit(reg_addr, `REG_HOLD_RELEASE);
	assign wr_source  = reg_wr && hit(reg_addr, `REG_SOURCE_SELECT);
	assign wr_enable  = reg_wr && hit(reg_addr, `REG_ENGINE_ENABLE);
	assign wr_restart = reg_wr && hit(reg_addr, `REG_AUTO_RESTART);

	assign now_vec[`TRACK_LEVEL] = reg_data_type'(level_now);
	assign now_vec[`TRACK_GAIN]  = gain_now;
	assign now_vec[`TRACK_LIMIT] = limiter_now;

	// deepest-value captures; a read reloads the slot read
	genvar gi;
	generate
		for (gi = 0; gi < `TRACK_COUNT; gi++) begin : trk
			track_if #(.WIDTH(`DATA_W)) link ();
			deepest_tracker #(.WIDTH(`DATA_W)) u_track (
				.clk  (clk),
				.rst  (rst),
				.port (link.owner)
			);
			assign link.now  = now_vec[gi];
			// RQ4 reload on read
			assign link.take = reg_rd && hit(reg_addr, track_addr(gi));
			assign held_vec[gi] = link.held;
		end
	endgenerate

	// control register group
	logic hold_release_d;
	logic engine_input_select_d;
	logic engine_enable_d;
	logic limiter_enable_d;
	logic overcurrent_auto_recover_d;
	logic thermal_auto_recover_d;
	logic battery_rail_auto_recover_d;
	logic speaker_rail_auto_recover_d;

	always_comb begin
		// RQ13 release is a pulse
		hold_release_d = `RESET_BIT;
		// RQ1 only a one releases
		if (wr_hold) begin
			hold_release_d = reg_wdata[`BIT_HOLD_RELEASE];
		end
		engine_input_select_d = engine_input_select_q;
		// RQ2 input channel choice
		if (wr_source) begin
			engine_input_select_d = reg_wdata[`BIT_INPUT_SELECT];
		end
		engine_enable_d  = engine_enable_q;
		limiter_enable_d = limiter_enable_q;
		if (wr_enable) begin
			// RQ8 engine on bit
			engine_enable_d  = reg_wdata[`BIT_ENGINE_EN];
			// RQ7 limiter on bit
			limiter_enable_d = reg_wdata[`BIT_LIMITER_EN];
		end
		overcurrent_auto_recover_d  = overcurrent_auto_recover_q;
		thermal_auto_recover_d      = thermal_auto_recover_q;
		battery_rail_auto_recover_d = battery_rail_auto_recover_q;
		speaker_rail_auto_recover_d = speaker_rail_auto_recover_q;
		if (wr_restart) begin
			// RQ9 overcurrent auto mode
			overcurrent_auto_recover_d  = reg_wdata[`BIT_OVC_RECOVER];
			// RQ10 thermal auto mode
			thermal_auto_recover_d      = reg_wdata[`BIT_THERM_RECOVER];
			// RQ11 battery lockout auto
			battery_rail_auto_recover_d = reg_wdata[`BIT_BAT_RECOVER];
			// RQ12 speaker lockout auto
			speaker_rail_auto_recover_d = reg_wdata[`BIT_SPK_RECOVER];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			hold_release_q              <= `RESET_BIT;
			engine_input_select_q       <= `RESET_BIT;
			engine_enable_q             <= `RESET_BIT;
			limiter_enable_q            <= `RESET_BIT;
			overcurrent_auto_recover_q  <= `RESET_BIT;
			thermal_auto_recover_q      <= `RESET_BIT;
			battery_rail_auto_recover_q <= `RESET_BIT;
			speaker_rail_auto_recover_q <= `RESET_BIT;
		end else begin
			hold_release_q              <= hold_release_d;
			engine_input_select_q       <= engine_input_select_d;
			engine_enable_q             <= engine_enable_d;
			limiter_enable_q            <= limiter_enable_d;
			overcurrent_auto_recover_q  <= overcurrent_auto_recover_d;
			thermal_auto_recover_q      <= thermal_auto_recover_d;
			battery_rail_auto_recover_q <= battery_rail_auto_recover_d;
			speaker_rail_auto_recover_q <= speaker_rail_auto_recover_d;
		end
	end

	// read path; data lands one cycle after the read strobe, so a
	// capture read returns the value held before its own reload
	reg_data_type reg_rdata_d;

	always_comb begin
		reg_rdata_d = `ZERO_BYTE;
		if (reg_rd) begin
			case (reg_addr)
				// RQ13 write-only reads zero
				`REG_HOLD_RELEASE:  reg_rdata_d = `ZERO_BYTE;
				`REG_SOURCE_SELECT: begin
					reg_rdata_d[`BIT_INPUT_SELECT] = engine_input_select_q;
				end
				// RQ3 level in low bits
				`REG_LOWEST_LEVEL:  reg_rdata_d = held_vec[`TRACK_LEVEL];
				// RQ5 gain capture
				`REG_LOWEST_GAIN:   reg_rdata_d = held_vec[`TRACK_GAIN];
				// RQ6 limiter capture
				`REG_LOWEST_LIMIT:  reg_rdata_d = held_vec[`TRACK_LIMIT];
				`REG_ENGINE_ENABLE: begin
					reg_rdata_d[`BIT_ENGINE_EN]  = engine_enable_q;
					reg_rdata_d[`BIT_LIMITER_EN] = limiter_enable_q;
				end
				`REG_AUTO_RESTART: begin
					reg_rdata_d[`BIT_OVC_RECOVER]   = overcurrent_auto_recover_q;
					reg_rdata_d[`BIT_THERM_RECOVER] = thermal_auto_recover_q;
					reg_rdata_d[`BIT_BAT_RECOVER]   = battery_rail_auto_recover_q;
					reg_rdata_d[`BIT_SPK_RECOVER]   = speaker_rail_auto_recover_q;
				end
				default:            reg_rdata_d = `ZERO_BYTE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata_q <= `RESET_BYTE;
		end else begin
			reg_rdata_q <= reg_rdata_d;
		end
	end

	// checks
	sequence s_release_write;
		wr_hold && reg_wdata[`BIT_HOLD_RELEASE];
	endsequence

	sequence s_pulse_once;
		hold_release_q ##1 !hold_release_q;
	endsequence

	// a second release write in the next cycle would stretch the pulse
	a_hold_pulse: assert property ( // RQ1
		@(posedge clk) disable iff (rst)
		s_release_write ##1
			!(wr_hold && reg_wdata[`BIT_HOLD_RELEASE]) |-> s_pulse_once
	) else $error("release did not pulse once");

	a_hold_zero_write: assert property ( // RQ13
		@(posedge clk) disable iff (rst)
		!(wr_hold && reg_wdata[`BIT_HOLD_RELEASE]) |=> !hold_release_q
	) else $error("release high without a release write");

	a_hold_reads_zero: assert property ( // RQ13
		@(posedge clk) disable iff (rst)
		reg_rd && hit(reg_addr, `REG_HOLD_RELEASE) |=>
			reg_rdata_q == `ZERO_BYTE
	) else $error("hold-release register read nonzero");

	a_source_hold: assert property ( // RQ2
		@(posedge clk) disable iff (rst)
		wr_source ##1 !wr_source [*2] |->
			engine_input_select_q == $past(reg_wdata[`BIT_INPUT_SELECT], 2)
	) else $error("input select not held from last write");

	a_level_code: assert property ( // RQ3
		@(posedge clk) disable iff (rst)
		reg_rd && hit(reg_addr, `REG_LOWEST_LEVEL) |=>
			reg_rdata_q == $past(held_vec[`TRACK_LEVEL]) &&
			reg_rdata_q[`DATA_W-1:`LEVEL_W] == '0
	) else $error("level read wrong or upper bits set");

	a_gain_read: assert property ( // RQ5
		@(posedge clk) disable iff (rst)
		reg_rd && hit(reg_addr, `REG_LOWEST_GAIN) |=>
			reg_rdata_q == $past(held_vec[`TRACK_GAIN])
	) else $error("gain read mismatch");

	a_limiter_read: assert property ( // RQ6
		@(posedge clk) disable iff (rst)
		reg_rd && hit(reg_addr, `REG_LOWEST_LIMIT) |=>
			reg_rdata_q == $past(held_vec[`TRACK_LIMIT])
	) else $error("limiter read mismatch");

	a_enable_bits: assert property ( // RQ7
		@(posedge clk) disable iff (rst)
		wr_enable |=> limiter_enable_q == $past(reg_wdata[`BIT_LIMITER_EN])
			&& engine_enable_q == $past(reg_wdata[`BIT_ENGINE_EN])
	) else $error("enable bits not taken from write");

	a_enable_reset: assert property ( // RQ8
		@(posedge clk)
		$past(rst) |-> !engine_enable_q && !limiter_enable_q
	) else $error("enable bits not zero after reset");

	a_restart_bits: assert property ( // RQ9
		@(posedge clk) disable iff (rst)
		wr_restart |=> overcurrent_auto_recover_q ==
			$past(reg_wdata[`BIT_OVC_RECOVER]) &&
			thermal_auto_recover_q == $past(reg_wdata[`BIT_THERM_RECOVER])
			&& battery_rail_auto_recover_q ==
			$past(reg_wdata[`BIT_BAT_RECOVER]) &&
			speaker_rail_auto_recover_q == $past(reg_wdata[`BIT_SPK_RECOVER])
	) else $error("restart bits not taken from write");

	a_restart_stable: assert property ( // RQ10
		@(posedge clk) disable iff (rst)
		!wr_restart |=> $stable(thermal_auto_recover_q) &&
			$stable(overcurrent_auto_recover_q) &&
			$stable(battery_rail_auto_recover_q) &&
			$stable(speaker_rail_auto_recover_q)
	) else $error("restart bit changed without a write");
endmodule

/* brownout_pkg.sv */
`include "brownout_defs.svh"

package brownout_pkg;

	typedef logic [`ADDR_W-1:0] reg_addr_type;
	typedef logic [`DATA_W-1:0] reg_data_type;

	typedef enum logic [`LEVEL_W-1:0] {
		LVL_INACTIVE = `LEVEL_INACTIVE,
		LVL_3        = `LEVEL_3,
		LVL_2        = `LEVEL_2,
		LVL_1        = `LEVEL_1,
		LVL_0        = `LEVEL_0
	} level_type;

	typedef struct packed {
		logic [`GAIN_INT_W-1:0]  whole_db;
		logic [`GAIN_FRAC_W-1:0] eighth_db;
	} gain_type;

	typedef struct packed {
		logic [`LIMIT_INT_W-1:0]  whole_db;
		logic [`LIMIT_FRAC_W-1:0] sixteenth_db;
	} limiter_type;

endpackage

/* deepest_tracker.sv */
`timescale 1ns/1ps
`include "brownout_defs.svh"

module deepest_tracker #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	track_if.owner   port
);
	logic [WIDTH-1:0] held_q;
	logic [WIDTH-1:0] held_d;

	// a read reloads with the live value so tracking restarts there
	always_comb begin
		held_d = held_q;
		if (port.take) begin
			held_d = port.now;
		end else if (port.now > held_q) begin
			held_d = port.now;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			held_q <= WIDTH'(`RESET_BYTE);
		end else begin
			held_q <= held_d;
		end
	end

	assign port.held = held_q;

	a_track_reload: assert property ( // RQ4
		@(posedge clk) disable iff (rst)
		port.take |=> held_q == $past(port.now)
	) else $error("capture not reloaded after read");

	a_track_never_rises: assert property ( // RQ5
		@(posedge clk) disable iff (rst)
		!port.take && port.now <= held_q |=> $stable(held_q)
	) else $error("capture lost its deepest value");

	a_track_follows: assert property ( // RQ6
		@(posedge clk) disable iff (rst)
		!port.take && port.now > held_q |=> held_q == $past(port.now)
	) else $error("capture missed a deeper value");
endmodule

/* live_source.sv */
`timescale 1ns/1ps

// stand-in for the brownout controller that feeds the live level, gain
// and limiter values; frozen it holds them, free it moves every cycle
module live_source
	import brownout_pkg::*;
(
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic                       freeze,
	output      brownout_pkg::level_type    level_now,
	output      brownout_pkg::gain_type     gain_now,
	output      brownout_pkg::limiter_type  limiter_now
);
	int seed = 4596;

	// reserved level codes are drawn too, they must be captured as given
	always @(negedge clk) begin
		if (rst) begin
			level_now <= LVL_INACTIVE;
			gain_now <= '0;
			limiter_now <= '0;
		end else if (!freeze) begin
			level_now <= level_type'(3'($random(seed)));
			gain_now <= gain_type'(8'($random(seed)));
			limiter_now <= limiter_type'(8'($random(seed)));
		end
	end
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
`include "brownout_defs.svh"

module tb_top;
	import brownout_pkg::*;
	logic         clk, rst, reg_wr, reg_rd, freeze, rd_pend;
	reg_addr_type reg_addr;
	reg_data_type reg_wdata, reg_rdata_q, v;
	level_type    level_now;
	gain_type     gain_now;
	limiter_type  limiter_now;
	logic [7:0]   ctl;
	int           miscompares, checked, seed, cycles, pulses;
	reg_data_type exp_q[$];
	reg_data_type cap[3];
	reg_data_type lv[3];

	brownout_engine_status_ctrl dut (
		.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.level_now(level_now), .gain_now(gain_now),
		.limiter_now(limiter_now), .hold_release_q(ctl[0]),
		.engine_input_select_q(ctl[1]), .engine_enable_q(ctl[2]),
		.limiter_enable_q(ctl[3]), .overcurrent_auto_recover_q(ctl[4]),
		.thermal_auto_recover_q(ctl[5]),
		.battery_rail_auto_recover_q(ctl[6]),
		.speaker_rail_auto_recover_q(ctl[7])
	);

	live_source src (
		.clk(clk), .rst(rst), .freeze(freeze), .level_now(level_now),
		.gain_now(gain_now), .limiter_now(limiter_now)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic summarize;
		if (miscompares == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic cmp_byte(input reg_data_type e, input reg_data_type g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("Error t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic cmp_bit(input logic e, input logic g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("Error t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic wr(input reg_addr_type a, input reg_data_type d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask

	// k selects a capture slot whose expectation comes from the model
	task automatic rd(input reg_addr_type a, input reg_data_type e,
			input int k);
		@(negedge clk);
		if (k >= 0)
			e = cap[k];
		reg_addr = a;
		reg_rd = 1'b1;
		exp_q.push_back(e);
		@(negedge clk);
		reg_rd = 1'b0;
	endtask

	assign lv[0] = {5'h00, level_now};
	assign lv[1] = gain_now;
	assign lv[2] = limiter_now;

	// running maximum, reloaded with the live value on a read
	always @(posedge clk) begin
		for (int k = 0; k < 3; k++) begin
			if (rst)
				cap[k] = 8'h00;
			else if (reg_rd && reg_addr == `REG_LOWEST_LEVEL + k)
				cap[k] = lv[k];
			else if (lv[k] > cap[k])
				cap[k] = lv[k];
		end
		rd_pend <= reg_rd;
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			summarize();
		end
	end

	always @(negedge clk) begin
		if (rd_pend)
			cmp_byte(exp_q.pop_front(), reg_rdata_q);
		if (ctl[0] === 1'b1)
			pulses++;
	end

	initial begin
		seed = 4596;
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 8'h00;
		freeze = 1'b1;
		miscompares = 0;
		checked = 0;
		cycles = 0;
		pulses = 0;
		repeat (12) @(negedge clk);
		rst = 1'b0;
		// every register and the unmapped gap read zero after reset
		for (int i = 0; i < 8; i++)
			rd(`REG_HOLD_RELEASE + i, 8'h00, (i >= 2 && i <= 4) ? i - 2 : -1);
		cmp_byte(8'h00, ctl);
		repeat (6) begin
			v = 8'($random(seed));
			wr(`REG_ENGINE_ENABLE, v);
			cmp_bit(v[0], ctl[2]);
			cmp_bit(v[1], ctl[3]);
			rd(`REG_ENGINE_ENABLE, v & 8'h03, -1);
			wr(`REG_SOURCE_SELECT, v);
			cmp_bit(v[0], ctl[1]);
			rd(`REG_SOURCE_SELECT, v & 8'h01, -1);
			wr(`REG_AUTO_RESTART, v);
			cmp_bit(v[3], ctl[4]);
			cmp_bit(v[2], ctl[5]);
			cmp_bit(v[1], ctl[6]);
			cmp_bit(v[0], ctl[7]);
			rd(`REG_AUTO_RESTART, v & 8'h0f, -1);
		end
		// refused writes: unmapped place and a read-only capture
		wr(16'h210c, 8'hff);
		wr(`REG_LOWEST_GAIN, 8'hff);
		rd(16'h210c, 8'h00, -1);
		// only writes with bit 0 set release the hold, one cycle each
		wr(`REG_HOLD_RELEASE, 8'hfe);
		wr(`REG_HOLD_RELEASE, 8'h01);
		wr(`REG_HOLD_RELEASE, 8'hff);
		rd(`REG_HOLD_RELEASE, 8'h00, -1);
		repeat (2) @(negedge clk);
		cmp_byte(8'h02, 8'(pulses));
		repeat (40) begin
			freeze = 1'($random(seed));
			repeat ($random(seed) & 3) @(negedge clk);
			for (int k = 0; k < 3; k++)
				rd(`REG_LOWEST_LEVEL + k, 8'h00, k);
		end
		repeat (3) @(negedge clk);
		summarize();
	end
endmodule

/* track_if.sv */
`timescale 1ns/1ps

interface track_if #(
	parameter int WIDTH = 8
);
	logic [WIDTH-1:0] now;
	logic             take;
	logic [WIDTH-1:0] held;

	modport owner (
		input  now,
		input  take,
		output held
	);

	modport user (
		output now,
		output take,
		input  held
	);
endinterface
